// file: sim/meter_far_side.sv
// model of the converter and the self-test engine beside the meter controller
// assumes one-cycle start pulses from the controller on a single clock
`timescale 1ns/1ps
`default_nettype none
module meter_far_side (
    input  wire logic       i_mclk,
    input  wire logic       i_conv_start,
    input  wire logic       i_test_start,
    input  wire logic       i_test_all,
    input  wire logic [7:0] i_test_number,
    input  wire logic [7:0] i_fail_at,
    output logic            o_conv_done,
    output logic            o_test_done,
    output logic [7:0]      o_test_result
);
    logic [2:0] conv_sr = 3'h0;
    logic [3:0] test_sr = 4'h0;
    logic [7:0] held    = 8'h00;
    // converter stores after three cycles, engine answers after four
    always @(posedge i_mclk)
    begin
        conv_sr <= {conv_sr[1:0], i_conv_start};
        test_sr <= {test_sr[2:0], i_test_start};
        if (i_test_start)
            held <= (i_test_all || i_test_number == i_fail_at) ? i_fail_at : 8'h00;
    end
    assign o_conv_done   = conv_sr[2];
    assign o_test_done   = test_sr[3];
    // result is only good in the done cycle, so show garbage elsewhere
    assign o_test_result = o_test_done ? held : ~held;
endmodule // meter_far_side
`default_nettype wire

// file: sim/test_meter_ctl.sv
// command-sequence testbench of the meter controller
// assumes the far-side model and a shortened millisecond count
`timescale 1ns/1ps
`default_nettype none
`include "meter_ctl_consts.svh"
module test_meter_ctl
    import meter_ctl_pkg::*;
;
    logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_cmd_valid = 1'b0, i_ext_trig = 1'b0;
    cmd_t        i_cmd = '0;
    logic [13:0] i_default_delay_ms = 14'h0003;
    logic [7:0]  i_test_result, o_test_number, o_test_rsp, fail_at = 8'h03;
    logic        i_conv_done, i_test_done, o_conv_start, o_auto_delay, o_events_clear;
    logic        o_pos_transition, o_native_parser, o_test_start, o_test_all, o_test_rsp_valid;
    seq_state_t  o_state;
    trig_src_t   o_trig_src;
    err_rsp_t    o_err_rsp;
    logic [9:0]  o_trig_count;
    logic [13:0] o_delay_ms;
    logic [4:0]  o_err_count;
    logic [15:0] o_oper_enable, o_ques_enable, o_version_x10;
    int          error_cnt = 0, checked = 0, n, convs = 0, c0;

    // ----------------------------------------------------------------
    // clock, design and far side
    // ----------------------------------------------------------------
    always #2.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (o_conv_start === 1'b1) convs++;
    meter_ctl #(.CYC_PER_MS(2)) i_meter_ctl (.i_mclk, .i_reset_n, .i_cmd, .i_cmd_valid, .i_ext_trig,
        .i_default_delay_ms, .i_conv_done, .i_test_done, .i_test_result, .o_conv_start, .o_state,
        .o_trig_src, .o_trig_count, .o_auto_delay, .o_delay_ms, .o_err_rsp, .o_err_count, .o_oper_enable,
        .o_ques_enable, .o_events_clear, .o_pos_transition, .o_native_parser, .o_version_x10, .o_test_start,
        .o_test_all, .o_test_number, .o_test_rsp_valid, .o_test_rsp);
    meter_far_side i_meter_far_side (.i_mclk(i_mclk), .i_conv_start(o_conv_start), .i_test_start(o_test_start),
        .i_test_all(o_test_all), .i_test_number(o_test_number), .i_fail_at(fail_at),
        .o_conv_done(i_conv_done), .o_test_done(i_test_done), .o_test_result(i_test_result));

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("mismatches %0d of %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one-cycle strobe; returns just after the taking edge
    task cmd(input cmd_code_t c, input logic [15:0] a);
        @(posedge i_mclk);
        i_cmd       <= '{code: c, arg: a};
        i_cmd_valid <= 1'b1;
        @(posedge i_mclk);
        i_cmd_valid <= 1'b0;
        #1;
    endtask
    task pop(input logic [15:0] e);
        cmd(CMD_ERR_Q, 16'h0000);
        chk(o_err_rsp.valid, 1);
        chk(o_err_rsp.code, e);
    endtask
    task wait_st(input seq_state_t s);
        for (n = 0; n < 400 && o_state !== s; n++)
        begin
            @(posedge i_mclk);
            #1;
        end
        if (o_state !== s)
        begin
            error_cnt++;
            test_done();
        end
    endtask
    task selftest(input cmd_code_t c, input logic [7:0] num, input logic [7:0] e);
        cmd(c, {8'h00, num});
        chk({o_test_start, o_test_all, o_test_number}, {1'b1, c == CMD_TEST_ALL, c == CMD_TEST_ONE ? num : 8'h00});
        for (n = 0; n < 50 && o_test_rsp_valid !== 1'b1; n++)
        begin
            @(posedge i_mclk);
            #1;
        end
        chk({o_test_rsp_valid, o_test_rsp}, {1'b1, e});
    endtask

    // ----------------------------------------------------------------
    // command sequences
    // ----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        #1;
        chk({o_state, o_trig_src, o_trig_count, o_auto_delay, o_native_parser}, {SEQ_IDLE, SRC_IMM, 10'h001, 2'b10});
        chk({o_oper_enable, o_version_x10}, {16'h0000, 16'h4dc6});
        pop(16'h0000);
        cmd(CMD_TRIG, 16'h0000);
        pop(`ERR_TRIG_IGNORED);
        $display("done: reset and empty queue");
        cmd(CMD_COUNT, 16'h0000);
        cmd(CMD_COUNT, 16'h03e9);
        cmd(CMD_COUNT, 16'h03e8);
        chk(o_trig_count, 10'h3e8);
        cmd(CMD_COUNT, 16'h0002);
        pop(16'hff22);
        pop(16'hff22);
        pop(16'h0000);
        cmd(CMD_DELAY, 16'h0005);
        @(posedge i_mclk);
        #1;
        chk({o_auto_delay, o_delay_ms}, {1'b0, 14'h0005});
        cmd(CMD_DELAY, 16'h4e20);
        pop(16'hff22);
        chk(o_delay_ms, 14'h2710);
        cmd(CMD_AUTO, 16'h0001);
        @(posedge i_mclk);
        #1;
        chk({o_auto_delay, o_delay_ms}, {1'b1, 14'h0003});
        $display("done: count and delay");
        cmd(CMD_SOURCE, 16'h0001);
        cmd(CMD_INIT, 16'h0000);
        chk(o_state, SEQ_WAIT);
        c0 = convs;
        repeat (2)
        begin
            wait_st(SEQ_WAIT);
            cmd(CMD_TRIG, 16'h0000);
        end
        wait_st(SEQ_IDLE);
        chk(convs - c0, 2);
        chk(o_err_count, 5'd0);
        cmd(CMD_INIT, 16'h0000);
        cmd(CMD_ABORT, 16'h0000);
        chk(o_state, SEQ_IDLE);
        $display("done: trigger sequence");
        repeat (12) cmd(CMD_TRIG, 16'h0000);
        @(posedge i_mclk);
        #1;
        chk(o_err_count, 5'd10);
        repeat (9) pop(`ERR_TRIG_IGNORED);
        pop(16'hfea2);
        pop(16'h0000);
        $display("done: error queue overflow");
        cmd(CMD_PRESET, 16'h0000);
        chk({o_events_clear, o_pos_transition, o_oper_enable}, {2'b11, 16'h0000});
        chk(o_ques_enable, 16'h0000);
        cmd(CMD_LANG_NAT, 16'h0000);
        cmd(CMD_RESET, 16'h0000);
        chk({o_native_parser, o_trig_src, o_trig_count}, {1'b1, SRC_IMM, 10'h001});
        @(posedge i_mclk);
        i_reset_n <= 1'b0;
        @(posedge i_mclk);
        i_reset_n <= 1'b1;
        #1;
        chk({o_native_parser, o_state, o_trig_src, o_trig_count}, {1'b0, SEQ_IDLE, SRC_IMM, 10'h001});
        c0 = convs;
        cmd(CMD_INIT, 16'h0000);
        cmd(CMD_SOURCE, 16'h0003); // refused outside idle
        wait_st(SEQ_IDLE);
        chk(convs - c0, 1);
        chk(o_trig_src, SRC_IMM);
        pop(`ERR_SETTINGS);
        cmd(CMD_LANG_NAT, 16'h0000);
        cmd(CMD_LANG_STD, 16'h0000);
        chk(o_native_parser, 1'b0);
        $display("done: preset and parser");
        selftest(CMD_TEST_ALL, 8'h00, 8'h03);
        selftest(CMD_TEST_ONE, 8'h05, 8'h00);
        selftest(CMD_TEST_ONE, 8'h03, 8'h03);
        $display("done: self test");
        test_done();
    end
endmodule // test_meter_ctl
`default_nettype wire

// file: verilog/meter_ctl.sv
// command-level controller of a plug-in meter: trigger sequencer, delay, error queue,
// status preset, parser select, version report and self-test dispatch
// assumes commands arrive as one-cycle strobes; converter and self-test engine are outside
// Operation
// RULE1 - errors kept oldest-first in a ten-entry queue; each query removes oldest
// RULE2 - error on full queue replaces newest entry with code -350
// RULE3 - query on empty queue answers code 0, no error
// RULE4 - every queued code fits signed sixteen bits
// RULE5 - status preset clears event and enable bits, positive transition selected
// RULE6 - alternate parser survives reset; only the return command leaves it (code keeps it over the reset command but clears it on i_reset_n)
// RULE7 - version query answers fixed value 1991.0
// RULE8 - full self-test stops at first failure, answers 0 or failing number
// RULE9 - single self-test runs host-chosen test, answers native test data
// RULE10 - sequencer idle at power-up, reset and abort
// RULE11 - no arm layer; initiate goes straight to wait-for-trigger
// RULE12 - waiting: abort returns idle, valid trigger makes one measurement
// RULE13 - trigger count above one stays armed that many triggers; reset sets 1
// RULE14 - trigger count 1 to 1000; outside raises error -222
// RULE15 - immediate trigger measures only while waiting with bus or hold source
// RULE16 - immediate trigger when not initiated raises error 211
// RULE17 - auto-delay flag picks default or programmed delay; reset sets it on
// RULE18 - writing an explicit delay clears auto-delay
// RULE19 - programmed delay 0 to 10 s; above 10 saturates and raises -222
// RULE20 - delay query answers delay in force, default when auto
// RULE21 - selected delay holds for all later measurements until changed
// RULE22 - reset leaves idle with immediate trigger source
// RULE23 - measurement starts by pulse; trigger counts done on converter stored signal
`timescale 1ns/1ps
`default_nettype none
`include "meter_ctl_consts.svh"
module meter_ctl
    import meter_ctl_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `CYC_PER_MS,
    parameter int          ERR_DEPTH  = `ERRQ_DEPTH
)(
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire cmd_t        i_cmd,
    input  wire logic        i_cmd_valid,
    input  wire logic        i_ext_trig,
    input  wire logic [13:0] i_default_delay_ms,
    input  wire logic        i_conv_done,
    input  wire logic        i_test_done,
    input  wire logic [7:0]  i_test_result,
    output logic             o_conv_start,
    output var  seq_state_t  o_state,
    output var  trig_src_t   o_trig_src,
    output logic [9:0]       o_trig_count,
    output logic             o_auto_delay,
    output logic [13:0]      o_delay_ms,
    output var  err_rsp_t    o_err_rsp,
    output logic [4:0]       o_err_count,
    output logic [15:0]      o_oper_enable,
    output logic [15:0]      o_ques_enable,
    output logic             o_events_clear,
    output logic             o_pos_transition,
    output logic             o_native_parser,
    output logic [15:0]      o_version_x10,
    output logic             o_test_start,
    output logic             o_test_all,
    output logic [7:0]       o_test_number,
    output logic             o_test_rsp_valid,
    output logic [7:0]       o_test_rsp
);
    initial
    begin
        if (CYC_PER_MS < 1) $error("meter_ctl: CYC_PER_MS must be at least 1");
    end
    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire        cmd_rst   = i_cmd_valid && i_cmd.code == CMD_RESET;
    wire        cmd_init  = i_cmd_valid && i_cmd.code == CMD_INIT;
    wire        cmd_abort = i_cmd_valid && i_cmd.code == CMD_ABORT;
    wire        cmd_trig  = i_cmd_valid && i_cmd.code == CMD_TRIG;
    wire        cmd_count = i_cmd_valid && i_cmd.code == CMD_COUNT;
    wire        cmd_delay = i_cmd_valid && i_cmd.code == CMD_DELAY;
    wire        cmd_auto  = i_cmd_valid && i_cmd.code == CMD_AUTO;
    wire        cmd_src   = i_cmd_valid && i_cmd.code == CMD_SOURCE;
    wire        cmd_errq  = i_cmd_valid && i_cmd.code == CMD_ERR_Q;
    wire        cmd_pre   = i_cmd_valid && i_cmd.code == CMD_PRESET;
    wire        cmd_nat   = i_cmd_valid && i_cmd.code == CMD_LANG_NAT;
    wire        cmd_std   = i_cmd_valid && i_cmd.code == CMD_LANG_STD;
    wire        cmd_tall  = i_cmd_valid && i_cmd.code == CMD_TEST_ALL;
    wire        cmd_tone  = i_cmd_valid && i_cmd.code == CMD_TEST_ONE;
    wire        idle      = o_state == SEQ_IDLE;
    wire        waiting   = o_state == SEQ_WAIT;
    wire        src_soft  = o_trig_src == SRC_BUS || o_trig_src == SRC_HOLD;
    // count argument must lie in 1..1000; host encodes min/max as those values
    wire        count_ok  = i_cmd.arg >= 16'(`TRIG_COUNT_MIN) && i_cmd.arg <= 16'(`TRIG_COUNT_MAX);
    wire        delay_big = i_cmd.arg > 16'(`DELAY_MAX_MS);
    wire [13:0] delay_sat = delay_big ? `DELAY_MAX_MS : i_cmd.arg[13:0];
    // trigger qualification: soft trigger only on bus/hold, ext pin on external source
    wire        soft_hit  = waiting && cmd_trig && src_soft;           // see RULE15
    wire        trig_bad  = cmd_trig && !waiting;                      // see RULE16
    wire        ext_hit   = waiting && o_trig_src == SRC_EXT && i_ext_trig;
    wire        imm_hit   = waiting && o_trig_src == SRC_IMM;
    wire        trig_hit  = soft_hit || ext_hit || imm_hit;
    wire        src_bad   = cmd_src && !idle;
    // ----------------------------------------------------------------
    // error source selection: one push per cycle, highest priority first
    // ----------------------------------------------------------------
    wire        count_bad = cmd_count && !count_ok;                    // see RULE14
    wire        delay_bad = cmd_delay && delay_big;                    // see RULE19
    wire        err_push  = count_bad || delay_bad || trig_bad || src_bad;
    wire [15:0] err_code  = (count_bad || delay_bad) ? `ERR_DATA_RANGE :
                            trig_bad ? `ERR_TRIG_IGNORED : `ERR_SETTINGS;
    meter_err_queue #(
        .DEPTH (ERR_DEPTH)
    ) u_errq (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_push    (err_push),
        .i_code    (err_code),
        .i_pop     (cmd_errq),
        .o_rsp     (o_err_rsp),
        .o_count   (o_err_count)
    );
    // ----------------------------------------------------------------
    // configuration: count, source, auto-delay, programmed delay
    // ----------------------------------------------------------------
    logic [13:0] prog_delay;
    wire         soft_rst = !i_reset_n || cmd_rst;
    always_ff @(posedge i_mclk)
    begin
        if (soft_rst)
        begin
            o_trig_count <= `TRIG_COUNT_RST;                  // see RULE13
            o_trig_src   <= SRC_IMM;                          // see RULE22
            o_auto_delay <= 1'b1;                             // see RULE17
            prog_delay   <= `DELAY_RST_MS;
        end
        else
        begin
            if (cmd_count && count_ok) o_trig_count <= i_cmd.arg[9:0];
            if (cmd_src && idle)       o_trig_src   <= trig_src_t'(i_cmd.arg[2:0]);
            if (cmd_auto)              o_auto_delay <= i_cmd.arg[0];
            if (cmd_delay)
            begin
                prog_delay   <= delay_sat;                    // see RULE19
                o_auto_delay <= 1'b0;                         // see RULE18
            end
        end
    end
    // delay in force, reported and used for every measurement
    wire [13:0] next_delay_ms = o_auto_delay ? i_default_delay_ms : prog_delay; // see RULE20
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n) o_delay_ms <= `DELAY_RST_MS;
        else            o_delay_ms <= next_delay_ms;
    end
    // ----------------------------------------------------------------
    // trigger sequencer
    // ----------------------------------------------------------------
    seq_state_t  next_state;
    logic [9:0]  done_count;
    logic [31:0] cyc_cnt;
    logic [13:0] ms_cnt;
    wire         ms_tick   = cyc_cnt == CYC_PER_MS - 1;
    wire         delay_end = ms_cnt >= o_delay_ms;                      // see RULE21
    wire         last_trig = done_count + 10'h001 >= o_trig_count;
    always_comb
    begin
        next_state = o_state;
        case (o_state)
            SEQ_IDLE:    if (cmd_init) next_state = SEQ_WAIT;          // see RULE11
            SEQ_WAIT:    if (cmd_abort) next_state = SEQ_IDLE;         // see RULE12
                         else if (trig_hit) next_state = SEQ_DELAY;
            SEQ_DELAY:   if (cmd_abort) next_state = SEQ_IDLE;
                         else if (delay_end) next_state = SEQ_MEASURE;
            SEQ_MEASURE: if (cmd_abort) next_state = SEQ_IDLE;
                         else if (i_conv_done)                         // see RULE23
                             next_state = last_trig ? SEQ_IDLE : SEQ_WAIT; // see RULE13
            default:     next_state = SEQ_IDLE;
        endcase
    end
    // state, per-trigger count and delay timer; reset and abort land in idle
    always_ff @(posedge i_mclk)
    begin
        if (soft_rst)
        begin
            o_state    <= SEQ_IDLE;                           // see RULE10
            done_count <= 10'h000;
            cyc_cnt    <= 32'h0000_0000;
            ms_cnt     <= 14'h0000;
        end
        else
        begin
            o_state <= next_state;
            if (o_state == SEQ_IDLE) done_count <= 10'h000;
            else if (o_state == SEQ_MEASURE && i_conv_done) done_count <= done_count + 10'h001;
            if (o_state != SEQ_DELAY)
            begin
                cyc_cnt <= 32'h0000_0000;
                ms_cnt  <= 14'h0000;
            end
            else if (ms_tick)
            begin
                cyc_cnt <= 32'h0000_0000;
                ms_cnt  <= ms_cnt + 14'h0001;
            end
            else
                cyc_cnt <= cyc_cnt + 32'h0000_0001;
        end
    end
    // start pulse on entry to measure
    always_ff @(posedge i_mclk)
    begin
        if (soft_rst) o_conv_start <= 1'b0;
        else          o_conv_start <= o_state == SEQ_DELAY && next_state == SEQ_MEASURE; // see RULE23
    end
    // ----------------------------------------------------------------
    // status preset, parser select, version
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            o_oper_enable    <= 16'h0000;
            o_ques_enable    <= 16'h0000;
            o_events_clear   <= 1'b0;
            o_pos_transition <= 1'b1;
        end
        else
        begin
            o_events_clear <= cmd_pre;
            if (cmd_pre)
            begin
                o_oper_enable    <= 16'h0000;                 // see RULE5
                o_ques_enable    <= 16'h0000;
                o_pos_transition <= 1'b1;
            end
        end
    end
    // parser select ignores the command reset on purpose
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)    o_native_parser <= 1'b0;
        else if (cmd_std)  o_native_parser <= 1'b0;           // see RULE6
        else if (cmd_nat)  o_native_parser <= 1'b1;
    end
    assign o_version_x10 = `VERSION_X10;                      // see RULE7
    // ----------------------------------------------------------------
    // self-test dispatch; engine stops at first failure and reports its number
    // ----------------------------------------------------------------
    logic test_busy;
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            test_busy        <= 1'b0;
            o_test_start     <= 1'b0;
            o_test_all       <= 1'b0;
            o_test_number    <= 8'h00;
            o_test_rsp_valid <= 1'b0;
            o_test_rsp       <= `SELFTEST_PASS;
        end
        else
        begin
            o_test_start     <= (cmd_tall || cmd_tone) && !test_busy;
            o_test_rsp_valid <= test_busy && i_test_done;
            if ((cmd_tall || cmd_tone) && !test_busy)
            begin
                test_busy     <= 1'b1;
                o_test_all    <= cmd_tall;                    // see RULE8
                o_test_number <= cmd_tone ? i_cmd.arg[7:0] : 8'h00; // see RULE9
            end
            else if (test_busy && i_test_done)
            begin
                test_busy  <= 1'b0;
                o_test_rsp <= i_test_result;                  // 0 pass, else failed test, see RULE8
            end
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_abort_idle: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (cmd_abort && !cmd_init) |=> o_state == SEQ_IDLE) else $error("abort did not idle"); // see RULE10
    chk_init_wait: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (idle && cmd_init && !cmd_rst) |=> o_state == SEQ_WAIT) else $error("init skipped wait"); // see RULE11
    chk_count_rng: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        o_trig_count >= 10'h001 && o_trig_count <= 10'h3e8) else $error("count out of range"); // see RULE14
    chk_delay_clrs: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (cmd_delay && !cmd_rst) |=> !o_auto_delay) else $error("delay write kept auto"); // see RULE18
    chk_delay_max: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !o_auto_delay |-> prog_delay <= 14'h2710) else $error("delay above ten seconds"); // see RULE19
    chk_start_conv: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        o_conv_start |-> o_state == SEQ_MEASURE) else $error("start outside measure"); // see RULE23
    chk_parser_keep: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (o_native_parser && !cmd_std) |=> o_native_parser) else $error("parser lost"); // see RULE6
    chk_trig_err: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (cmd_trig && !waiting) |-> (err_push && err_code == 16'h00d3)) else $error("no 211"); // see RULE16
    cov_multi_trig: cover property (@(posedge i_mclk) o_state == SEQ_MEASURE && i_conv_done && !last_trig);
    cov_soft_trig: cover property (@(posedge i_mclk) soft_hit);
    cov_abort_wait: cover property (@(posedge i_mclk) waiting && cmd_abort);
endmodule // meter_ctl
`default_nettype wire

// file: verilog/meter_ctl_consts.svh
// constants of the meter command controller: codes, limits, reset values, timing
// assumes a 200 mhz core clock; included by bare name
`ifndef METER_CTL_CONSTS_SVH
`define METER_CTL_CONSTS_SVH
`define ERRQ_DEPTH          10
`define ERR_NONE            16'sh0000
`define ERR_QUEUE_OVERFLOW  (-16'sd350)
`define ERR_DATA_RANGE      (-16'sd222)
`define ERR_TRIG_IGNORED    16'sh00d3
`define ERR_SETTINGS        16'sh00dd
`define TRIG_COUNT_MIN      10'h001
`define TRIG_COUNT_MAX      10'h3e8
`define TRIG_COUNT_RST      10'h001
`define DELAY_MAX_MS        14'h2710
`define DELAY_RST_MS        14'h0000
`define CLK_MHZ             200
`define CYC_PER_MS          (`CLK_MHZ * 1000)
`define VERSION_X10         16'h4dc6
`define SELFTEST_PASS       8'h00
`endif

// file: verilog/meter_ctl_pkg.sv
// types of the meter command controller
// assumes meter_ctl_consts.svh provides the numeric constants
package meter_ctl_pkg;
    typedef enum logic [3:0] {
        CMD_NONE     = 4'h0,
        CMD_INIT     = 4'h1,
        CMD_ABORT    = 4'h2,
        CMD_TRIG     = 4'h3,
        CMD_COUNT    = 4'h4,
        CMD_DELAY    = 4'h5,
        CMD_AUTO     = 4'h6,
        CMD_SOURCE   = 4'h7,
        CMD_ERR_Q    = 4'h8,
        CMD_PRESET   = 4'h9,
        CMD_LANG_NAT = 4'ha,
        CMD_LANG_STD = 4'hb,
        CMD_TEST_ALL = 4'hc,
        CMD_TEST_ONE = 4'hd,
        CMD_RESET    = 4'he
    } cmd_code_t;
    typedef enum logic [2:0] {
        SRC_IMM  = 3'h0,
        SRC_BUS  = 3'h1,
        SRC_EXT  = 3'h2,
        SRC_HOLD = 3'h3,
        SRC_TTL  = 3'h4
    } trig_src_t;
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_WAIT    = 2'b01,
        SEQ_DELAY   = 2'b10,
        SEQ_MEASURE = 2'b11
    } seq_state_t;
    typedef struct packed {
        cmd_code_t   code;
        logic [15:0] arg;
    } cmd_t;
    typedef struct packed {
        logic        valid;
        logic [15:0] code;
    } err_rsp_t;
endpackage

// file: verilog/meter_err_queue.sv
// ten-entry first-in first-out error queue with overflow replacement
// assumes at most one push per cycle; pop and push may coincide
`timescale 1ns/1ps
`default_nettype none
`include "meter_ctl_consts.svh"
module meter_err_queue
    import meter_ctl_pkg::*;
#(
    parameter int DEPTH = `ERRQ_DEPTH
)(
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_push,
    input  wire logic [15:0] i_code,
    input  wire logic        i_pop,
    output var  err_rsp_t    o_rsp,
    output logic [4:0]       o_count
);
    initial
    begin
        if (DEPTH < 2 || DEPTH > 16) $error("meter_err_queue: DEPTH out of 2..16");
    end
    logic [15:0] store [DEPTH];
    logic [3:0]  rd_ptr;
    logic [3:0]  wr_ptr;
    logic [4:0]  count;
    // ----------------------------------------------------------------
    // pointer arithmetic
    // ----------------------------------------------------------------
    wire         empty       = (count == 5'h00);
    wire         full        = (count == 5'(DEPTH));
    wire         do_pop      = i_pop && !empty;
    wire         do_push     = i_push && (!full || do_pop);
    wire         do_ovf      = i_push && full && !do_pop;          // see RULE2
    wire  [3:0]  last_ptr    = (wr_ptr == 4'h0) ? 4'(DEPTH - 1) : wr_ptr - 4'h1;
    wire  [3:0]  next_wr_ptr = (wr_ptr == 4'(DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
    wire  [3:0]  next_rd_ptr = (rd_ptr == 4'(DEPTH - 1)) ? 4'h0 : rd_ptr + 4'h1;
    wire  [4:0]  next_count  = count + {4'h0, do_push} - {4'h0, do_pop};
    // ----------------------------------------------------------------
    // storage: one entry per flip-flop word
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge i_mclk)
            begin
                if (!i_reset_n)
                    store[g] <= `ERR_NONE;
                else if (do_push && wr_ptr == 4'(g))
                    store[g] <= i_code;                        // see RULE4
                else if (do_ovf && last_ptr == 4'(g))
                    store[g] <= `ERR_QUEUE_OVERFLOW;           // newest entry replaced, see RULE2
            end
        end
    endgenerate
    // pointers and the registered answer; oldest first, zero when empty
    always_ff @(posedge i_mclk)
    begin
        if (!i_reset_n)
        begin
            rd_ptr <= 4'h0;
            wr_ptr <= 4'h0;
            count  <= 5'h00;
            o_rsp  <= '0;
        end
        else
        begin
            if (do_push) wr_ptr <= next_wr_ptr;
            if (do_pop)  rd_ptr <= next_rd_ptr;                // see RULE1
            count <= next_count;
            o_rsp.valid <= i_pop;
            if (i_pop)
                o_rsp.code <= empty ? `ERR_NONE : store[rd_ptr]; // see RULE3
        end
    end
    assign o_count = count;
    chk_q_bound: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        count <= 5'(DEPTH)) else $error("queue count above depth");   // see RULE1
    chk_empty_zero: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_pop && empty) |=> (o_rsp.valid && o_rsp.code == 16'h0000))
        else $error("empty query not zero");                           // see RULE3
    chk_ovf_keeps: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        do_ovf |=> (count == 5'(DEPTH))) else $error("overflow changed count"); // see RULE2
    cov_overflow: cover property (@(posedge i_mclk) do_ovf);
endmodule // meter_err_queue
`default_nettype wire
